//--- src/sim_pkg.sv
// constants and types for the system integrity monitor
//
// Functional notes
// [RL1] static reset while supply below active threshold
// [RL2] threshold level picked by start-up option
// [RL3] drive shared reset pin low during reset
// [RL4] supply spikes shorter than filter time ignored
// [RL5] detector disabled by option makes no reset
// [RL6] watchdog underflow: pin low minimum pulse width
// [RL7] warning flag is live and read only
// [RL8] warning detector works only with detector enabled
// [RL9] source select: supply or external sense pin
// [RL10] warning irq on every flag toggle
// [RL11] no warning irq during reset delay crossing
// [RL12] enabling irq while warned gives one irq
// [RL13] clock glitch filter only with multiplier on
// [RL14] lost main clock switches to safe clock
// [RL15] recovered main clock switches back automatically
// [RL16] safe clock sets flag, optional irq
// [RL17] wait mode unchanged, enabled irqs wake
// [RL18] halt freezes register and stops clock guard
// [RL19] halt exit resumes config, reset restarts
// [RL20] irq needs enable and cleared global mask
// [RL21] no wake from halt by these events
// [RL22] reset held 256 or 4096 cycles after release
// [RL23] safe flag cleared by read after recovery
// [RL24] warning irq cleared on service entry
// [RL25] async inputs pass two-stage synchroniser
package sim_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RST_OUT_MIN_NS = 20000;
  localparam int RST_OUT_CYC = (RST_OUT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SPIKE_NS = 40;
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_SHORT = 256;
  localparam int DLY_LONG = 4096;
  localparam int CNT_W = 13;
  localparam logic [1:0] ADDR_CSR = 2'h0;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int B_SRC = 7;
  localparam int B_WIE = 6;
  localparam int B_WFLAG = 5;
  localparam int B_LVRF = 4;
  localparam int B_SIE = 2;
  localparam int B_SFLAG = 1;
  localparam int B_WDRF = 0;
  typedef enum logic [1:0] {
    SIM_ACTIVE,
    SIM_DELAY,
    SIM_RUN
  } sim_state_e;
  // start-up options, caught once after reset release
  typedef struct packed {
    logic lvd_en;
    logic [1:0] lvd_level;
    logic long_delay;
    logic css_en;
    logic pll_en;
  } sim_opt_s;
endpackage

//--- src/sim_top.sv
// system integrity monitor: supply reset, warning and clock guard
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sim_top (
  input wire logic clk, // 100 MHz cpu clock
  input wire logic rst_n, // async system reset
  input wire logic ce, // clock enable, freezes all state
  input wire logic [1:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire sim_pkg::sim_opt_s opt, // option straps
  input wire logic lvd_below, // async supply low comparator
  input wire logic avd_vdd_low, // async supply warning comparator
  input wire logic avd_ext_low, // async sense pin comparator
  input wire logic main_clk_lost, // async clock loss indication
  input wire logic wdg_underflow, // watchdog underflow pulse
  input wire logic rst_pin_in, // reset pin level, async
  output logic rst_pin_out, // reset pin drive value
  output logic rst_pin_oe, // reset pin output enable
  output logic cpu_rst, // core held in reset
  output logic lvd_thr_rising, // comparator uses rising threshold
  output logic [1:0] lvd_thr_sel, // threshold level
  output logic avd_src_ext, // warning input is sense pin
  output logic clk_sel_safe, // cpu clock from safe oscillator
  output logic safe_osc_en, // safe oscillator and guard on
  output logic glitch_filt_en, // clock glitch filter on
  input wire logic cpu_imask, // global interrupt mask set
  input wire logic wait_mode, // cpu in wait
  input wire logic halt_mode, // cpu in halt
  input wire logic avd_irq_ack, // warning service entry pulse
  output logic irq_avd, // warning interrupt request
  output logic irq_css, // clock guard interrupt request
  output logic wake_req // wake from wait
);
  sim_pkg::sim_opt_s opt_reg;
  logic opt_done_reg;
  localparam int CNT_W_L = sim_pkg::CNT_W;
  logic [1:0] s_lvd, s_vdd, s_ext, s_clk, s_pin;
  logic [1:0] oe_hist_reg;
  logic [CNT_W_L-1:0] spike_cnt_reg;
  logic lvd_filt_reg;
  sim_pkg::sim_state_e state_reg, state_next;
  logic [CNT_W_L-1:0] cnt_reg, cnt_next;
  logic src_reg, wie_reg, sie_reg;
  logic wflag_reg, lvrf_reg, wdrf_reg, sflag_reg;
  logic wpend_reg;
  logic [7:0] rdata_reg;
  logic pin_oe_reg, cpu_rst_reg, irq_avd_reg, irq_css_reg, wake_reg;
  logic safe_reg, osc_en_reg;

  // options are caught by a clock after release, never by the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_reg <= '0;
      opt_done_reg <= 1'b0;
    end else if (ce && !opt_done_reg) begin
      opt_reg <= opt;
      opt_done_reg <= 1'b1;
    end
  end

  // two-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_lvd <= 2'h3;
      s_vdd <= 2'h0;
      s_ext <= 2'h0;
      s_clk <= 2'h0;
      s_pin <= 2'h3;
      oe_hist_reg <= 2'h3;
    end else if (ce) begin
      // pin level lags our own release by the synchroniser depth
      oe_hist_reg <= {oe_hist_reg[0], pin_oe_reg};
      s_lvd <= {s_lvd[0], lvd_below}; // RL25
      s_vdd <= {s_vdd[0], avd_vdd_low}; // RL25
      s_ext <= {s_ext[0], avd_ext_low}; // RL25
      s_clk <= {s_clk[0], main_clk_lost}; // RL25
      s_pin <= {s_pin[0], rst_pin_in}; // RL25
    end
  end

  // spike filter: a new comparator level counts only once stable
  wire lvd_s = s_lvd[1];
  wire spike_done = spike_cnt_reg == CNT_W_L'(sim_pkg::SPIKE_CYC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spike_cnt_reg <= '0;
      lvd_filt_reg <= 1'b1;
    end else if (ce) begin
      if (lvd_s == lvd_filt_reg) spike_cnt_reg <= '0; // RL4
      else if (spike_done) begin
        lvd_filt_reg <= lvd_s; // RL4
        spike_cnt_reg <= '0;
      end else spike_cnt_reg <= spike_cnt_reg + 1'b1;
    end
  end

  // reset sources; a disabled detector never resets
  wire lvd_rst = opt_reg.lvd_en && lvd_filt_reg; // RL5
  wire wdg_ev = wdg_underflow && state_reg == sim_pkg::SIM_RUN;
  // mask the synced pin until our own release has passed both stages
  wire ext_rst = !s_pin[1] && !pin_oe_reg && !(|oe_hist_reg);
  wire [CNT_W_L-1:0] dly_cyc = opt_reg.long_delay ?
    CNT_W_L'(sim_pkg::DLY_LONG) : CNT_W_L'(sim_pkg::DLY_SHORT);
  wire [CNT_W_L-1:0] pulse_cyc = CNT_W_L'(sim_pkg::RST_OUT_CYC);

  // reset sequence: active phase, then option delay, then run
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      sim_pkg::SIM_ACTIVE: begin
        if (cnt_reg != '0) cnt_next = cnt_reg - 1'b1; // RL6
        if (!lvd_rst && cnt_reg <= 1 && opt_done_reg) begin // RL1
          state_next = sim_pkg::SIM_DELAY;
          cnt_next = dly_cyc - 1'b1; // RL22
        end
      end
      sim_pkg::SIM_DELAY: begin
        if (lvd_rst) state_next = sim_pkg::SIM_ACTIVE;
        else if (cnt_reg == '0) state_next = sim_pkg::SIM_RUN; // RL22
        else cnt_next = cnt_reg - 1'b1;
      end
      sim_pkg::SIM_RUN: begin
        if (lvd_rst || ext_rst) begin
          state_next = sim_pkg::SIM_ACTIVE; // RL1
          cnt_next = '0;
        end else if (wdg_ev) begin
          state_next = sim_pkg::SIM_ACTIVE;
          cnt_next = pulse_cyc; // RL6
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sim_pkg::SIM_ACTIVE;
      cnt_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // register access decode
  wire csr_hit = addr == sim_pkg::ADDR_CSR;
  wire frozen = halt_mode; // RL18
  wire csr_wr = wr && csr_hit && !frozen;
  wire csr_rd = rd && csr_hit;
  wire running = state_reg == sim_pkg::SIM_RUN;

  // warning comparator; input chosen by source select
  wire avd_on = opt_reg.lvd_en; // RL8
  wire avd_s = avd_on && (src_reg ? s_ext[1] : s_vdd[1]); // RL9
  wire avd_toggle = avd_s != wflag_reg;
  wire wie_rise = csr_wr && wdata[sim_pkg::B_WIE] && !wie_reg;
  // toggles inside the reset delay raise nothing
  wire wpend_set = running && avd_on && !frozen &&
    ((avd_toggle && wie_reg) || (wie_rise && wflag_reg)); // RL10 RL11 RL12

  // clock guard, stopped in halt
  wire guard_on = opt_reg.css_en && !halt_mode; // RL18
  wire lost = guard_on && s_clk[1];
  wire sflag_clr = csr_rd && !s_clk[1] && !frozen; // RL23

  // control and status bits; all but the warning pending bit frozen while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_reg <= 1'b0;
      wie_reg <= 1'b0;
      sie_reg <= 1'b0;
      wflag_reg <= 1'b0;
      sflag_reg <= 1'b0;
      wpend_reg <= 1'b0;
    end else if (ce) begin
      if (csr_wr) begin
        src_reg <= wdata[sim_pkg::B_SRC];
        wie_reg <= wdata[sim_pkg::B_WIE];
        sie_reg <= wdata[sim_pkg::B_SIE];
      end
      if (!frozen) wflag_reg <= avd_s; // RL7
      if (wpend_set) wpend_reg <= 1'b1; // RL10
      else if (avd_irq_ack || !running) wpend_reg <= 1'b0; // RL24 RL11
      if (lost) sflag_reg <= 1'b1; // RL16
      else if (sflag_clr) sflag_reg <= 1'b0; // RL23
    end
  end

  // reset cause flags survive cpu reset, except that a supply reset clears the watchdog flag; writing zero clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvrf_reg <= 1'b0;
      wdrf_reg <= 1'b0;
    end else if (ce) begin
      if (lvd_rst) lvrf_reg <= 1'b1;
      else if (csr_wr && !wdata[sim_pkg::B_LVRF]) lvrf_reg <= 1'b0;
      if (wdg_ev) wdrf_reg <= 1'b1;
      else if (lvd_rst) wdrf_reg <= 1'b0;
      else if (csr_wr && !wdata[sim_pkg::B_WDRF]) wdrf_reg <= 1'b0;
    end
  end

  // read data; writes never touch the live flag bit
  wire [7:0] csr_val = {src_reg, wie_reg, wflag_reg, lvrf_reg, 1'b0,
    sie_reg, sflag_reg && opt_reg.css_en, wdrf_reg}; // RL7
  wire [7:0] rd_val = csr_hit ? csr_val : 8'h00;

  // interrupts gated by enable and the global mask
  wire avd_req = wpend_reg && wie_reg && !cpu_imask; // RL20
  wire css_req = sflag_reg && sie_reg && opt_reg.css_en &&
    !cpu_imask; // RL16 RL20
  // halt wake is not given by these sources
  wire wake_now = wait_mode && !halt_mode &&
    (avd_req || css_req); // RL17 RL21

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      pin_oe_reg <= 1'b1;
      cpu_rst_reg <= 1'b1;
      irq_avd_reg <= 1'b0;
      irq_css_reg <= 1'b0;
      wake_reg <= 1'b0;
      safe_reg <= 1'b0;
      osc_en_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg <= rd ? rd_val : 8'h00;
      pin_oe_reg <= state_next != sim_pkg::SIM_RUN; // RL3 RL6
      cpu_rst_reg <= state_next != sim_pkg::SIM_RUN; // RL1 RL22
      irq_avd_reg <= avd_req && running;
      irq_css_reg <= css_req && running;
      wake_reg <= wake_now && running;
      safe_reg <= lost; // RL14 RL15
      osc_en_reg <= guard_on; // RL18 RL19
    end
  end

  assign rdata = rdata_reg;
  assign rst_pin_out = 1'b0; // open drain: only ever pulls low
  assign rst_pin_oe = pin_oe_reg;
  assign cpu_rst = cpu_rst_reg;
  assign lvd_thr_rising = cpu_rst_reg; // RL1
  assign lvd_thr_sel = opt_reg.lvd_level; // RL2
  assign avd_src_ext = src_reg;
  assign clk_sel_safe = safe_reg;
  assign safe_osc_en = osc_en_reg;
  assign glitch_filt_en = opt_reg.pll_en; // RL13
  assign irq_avd = irq_avd_reg;
  assign irq_css = irq_css_reg;
  assign wake_req = wake_reg;
endmodule // sim_top
`default_nettype wire

//--- sim/sim_rst_line.sv
// model of the other devices on the shared open-drain reset line
`timescale 1ns/1ps
`default_nettype none
module sim_rst_line (
  input wire logic drv_oe, // monitor pulls the line
  input wire logic drv_out, // monitor drive value
  input wire logic ext_pull_n, // another device pulls low when 0
  output logic line // resolved pin level
);
  // wired-and with a pull-up: any low driver wins, idle floats high
  assign line = !(drv_oe && !drv_out) && ext_pull_n;
endmodule // sim_rst_line
`default_nettype wire

//--- sim/sim_props.sv
// port assertions for the integrity monitor
`timescale 1ns/1ps
`default_nettype none
module sim_props (
  input wire logic clk, // cpu clock
  input wire logic rst_n, // async reset
  input wire sim_pkg::sim_opt_s opt, // option straps
  input wire logic lvd_below, // supply low comparator
  input wire logic main_clk_lost, // clock loss
  input wire logic wdg_underflow, // watchdog pulse
  input wire logic rst_pin_oe, // pin drive enable
  input wire logic cpu_rst, // core reset
  input wire logic lvd_thr_rising, // threshold choice
  input wire logic clk_sel_safe, // safe clock chosen
  input wire logic safe_osc_en, // guard running
  input wire logic cpu_imask, // global mask
  input wire logic halt_mode, // halt
  input wire logic irq_avd, // warning irq
  input wire logic irq_css, // guard irq
  input wire logic wake_req // wake from wait
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [12:0] oe_cnt;
  // length of the current pin pulse, saturating so long brown-outs stay sane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_cnt <= 13'h0000;
    else if (!rst_pin_oe) oe_cnt <= 13'h0000;
    else if (!(&oe_cnt)) oe_cnt <= oe_cnt + 13'h0001;
  end
  sequence s_low; (lvd_below && opt.lvd_en)[*8]; endsequence
  sequence s_lost; (main_clk_lost && opt.css_en && !halt_mode)[*5]; endsequence
  sequence s_back; (!main_clk_lost && !halt_mode)[*5]; endsequence
  property p_pin; cpu_rst |-> rst_pin_oe; endproperty
  a_pin: assert property (p_pin) else $error("pin not low in reset");
  property p_hold; $fell(rst_pin_oe) |-> oe_cnt >= sim_pkg::DLY_SHORT; endproperty
  a_hold: assert property (p_hold) else $error("reset delay short");
  property p_wdg; wdg_underflow && !cpu_rst |=> rst_pin_oe && cpu_rst; endproperty
  a_wdg: assert property (p_wdg) else $error("no watchdog reset");
  property p_lvd; s_low |-> ##[1:4] cpu_rst; endproperty
  a_lvd: assert property (p_lvd) else $error("no low supply reset");
  property p_thr; lvd_thr_rising == cpu_rst; endproperty
  a_thr: assert property (p_thr) else $error("threshold choice wrong");
  property p_safe; s_lost |-> clk_sel_safe; endproperty
  a_safe: assert property (p_safe) else $error("no safe switch");
  property p_back; s_back |-> !clk_sel_safe; endproperty
  a_back: assert property (p_back) else $error("no switch back");
  property p_halt; halt_mode [*4] |-> !safe_osc_en && !wake_req; endproperty
  a_halt: assert property (p_halt) else $error("guard or wake in halt");
  property p_mask; irq_avd || irq_css |-> !cpu_imask || !$past(cpu_imask); endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_rstq; cpu_rst && $past(cpu_rst) |-> !irq_avd && !irq_css; endproperty
  a_rstq: assert property (p_rstq) else $error("irq during reset");
endmodule // sim_props
bind sim_top sim_props sim_props_inst (.clk(clk), .rst_n(rst_n), .opt(opt),
  .lvd_below(lvd_below), .main_clk_lost(main_clk_lost),
  .wdg_underflow(wdg_underflow), .rst_pin_oe(rst_pin_oe), .cpu_rst(cpu_rst),
  .lvd_thr_rising(lvd_thr_rising), .clk_sel_safe(clk_sel_safe),
  .safe_osc_en(safe_osc_en), .cpu_imask(cpu_imask), .halt_mode(halt_mode),
  .irq_avd(irq_avd), .irq_css(irq_css), .wake_req(wake_req));
`default_nettype wire

//--- sim/tb_sim_top.sv
// self-checking bench for the integrity monitor
`timescale 1ns/1ps
`default_nettype none
module tb_sim_top;
  logic clk, rst_n, ce, wr, rd, rd_d, lvd_below, avd_vdd_low, avd_ext_low;
  logic main_clk_lost, wdg_underflow, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic cpu_rst, lvd_thr_rising, avd_src_ext, clk_sel_safe, safe_osc_en;
  logic glitch_filt_en, cpu_imask, wait_mode, halt_mode, avd_irq_ack;
  logic irq_avd, irq_css, wake_req, ext_pull_n;
  logic [1:0] addr, lvd_thr_sel;
  logic [7:0] wdata, rdata, r;
  logic [15:0] ent;
  logic [15:0] expq[$];
  sim_pkg::sim_opt_s opt;
  int n_errors, n_checks, n;
  sim_top sim_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .opt(opt),
    .lvd_below(lvd_below), .avd_vdd_low(avd_vdd_low),
    .avd_ext_low(avd_ext_low), .main_clk_lost(main_clk_lost),
    .wdg_underflow(wdg_underflow), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .cpu_rst(cpu_rst),
    .lvd_thr_rising(lvd_thr_rising), .lvd_thr_sel(lvd_thr_sel),
    .avd_src_ext(avd_src_ext), .clk_sel_safe(clk_sel_safe),
    .safe_osc_en(safe_osc_en), .glitch_filt_en(glitch_filt_en),
    .cpu_imask(cpu_imask), .wait_mode(wait_mode), .halt_mode(halt_mode),
    .avd_irq_ack(avd_irq_ack), .irq_avd(irq_avd), .irq_css(irq_css),
    .wake_req(wake_req));
  sim_rst_line sim_rst_line_inst (.drv_oe(rst_pin_oe), .drv_out(rst_pin_out),
    .ext_pull_n(ext_pull_n), .line(rst_pin_in));
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bus write and read; reads leave the expected masked value in the queue
  task automatic wr_csr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_csr(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back({m, e & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic wait_run(output int c);
    for (c = 0; c < 7000 && cpu_rst !== 1'b0; c++) @(negedge clk);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      ent = expq.pop_front();
      chk("rdata", ent[7:0], rdata & ent[15:8]);
    end
  end
  initial begin
    #300us;
    n_errors++;
    complete_run();
  end
  initial begin
    {clk, ce, wr, rd, lvd_below, avd_vdd_low, avd_ext_low} = 7'h00;
    {main_clk_lost, wdg_underflow, cpu_imask, wait_mode} = 4'h0;
    {halt_mode, avd_irq_ack, rst_n, addr, wdata} = 12'h000;
    ext_pull_n = 1'b1;
    ce = 1'b1;
    void'($urandom(32'h708EC2EB));
    opt = '{1'b1, 2'($urandom_range(2)), 1'b0, 1'b1, 1'b1};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(n);
    chk("boot", 8'h01, 8'(n >= sim_pkg::DLY_SHORT));
    chk("filt", 8'(opt.pll_en), 8'(glitch_filt_en));
    chk("level", 8'(opt.lvd_level), 8'(lvd_thr_sel));
    rd_csr(sim_pkg::ADDR_CSR, 8'hE6, sim_pkg::CSR_RESET);
    rd_csr(2'h3, 8'hFF, 8'h00);
    r = 8'($urandom);
    wr_csr(sim_pkg::ADDR_CSR, r);
    rd_csr(sim_pkg::ADDR_CSR, 8'hEE, r & 8'hC4);
    cyc(1);
    chk("src", 8'(r[7]), 8'(avd_src_ext));
    @(posedge clk);
    halt_mode <= 1'b1;
    wr_csr(sim_pkg::ADDR_CSR, ~r);
    rd_csr(sim_pkg::ADDR_CSR, 8'hC4, r);
    cyc(6);
    chk("osc_halt", 8'h00, 8'(safe_osc_en));
    @(posedge clk);
    halt_mode <= 1'b0;
    cyc(6);
    chk("osc_back", 8'h01, 8'(safe_osc_en));
    $display("test registers done");
    wait_mode <= 1'b1;
    // each source, each comparator edge: flag, irq, wake, mask, service
    for (int s = 0; s < 2; s++) begin
      wr_csr(sim_pkg::ADDR_CSR, {s[0], 7'h44});
      for (int v = 1; v >= 0; v--) begin
        @(posedge clk);
        if (s == 1) avd_ext_low <= v[0];
        else avd_vdd_low <= v[0];
        cyc(12);
        chk("irq_avd", 8'h01, 8'(irq_avd));
        chk("wake", 8'h01, 8'(wake_req));
        rd_csr(sim_pkg::ADDR_CSR, 8'h20, {2'h0, v[0], 5'h00});
        @(posedge clk);
        cpu_imask <= 1'b1;
        cyc(3);
        chk("masked", 8'h00, 8'(irq_avd));
        @(posedge clk);
        cpu_imask <= 1'b0;
        avd_irq_ack <= 1'b1;
        @(posedge clk);
        avd_irq_ack <= 1'b0;
        cyc(3);
        chk("ack", 8'h00, 8'(irq_avd));
      end
    end
    wait_mode <= 1'b0;
    $display("test warning done");
    // a short spike is dropped, a long low resets and hides warning edges
    @(posedge clk);
    lvd_below <= 1'b1;
    repeat (3) @(posedge clk);
    lvd_below <= 1'b0;
    cyc(12);
    chk("spike", 8'h00, 8'(cpu_rst));
    @(posedge clk);
    lvd_below <= 1'b1;
    avd_vdd_low <= 1'b1;
    cyc(20);
    chk("lvd", 8'h01, {rst_pin_in, lvd_thr_rising, cpu_rst} == 3'h3);
    @(posedge clk);
    lvd_below <= 1'b0;
    avd_vdd_low <= 1'b0;
    wait_run(n);
    cyc(2);
    chk("quiet", 8'h00, 8'(irq_avd));
    rd_csr(sim_pkg::ADDR_CSR, 8'h11, 8'h10);
    @(posedge clk);
    wdg_underflow <= 1'b1;
    @(posedge clk);
    wdg_underflow <= 1'b0;
    cyc(sim_pkg::RST_OUT_CYC - 4);
    chk("wdg_pulse", 8'h01, 8'(rst_pin_oe));
    wait_run(n);
    rd_csr(sim_pkg::ADDR_CSR, 8'h01, 8'h01);
    $display("test resets done");
    @(posedge clk);
    main_clk_lost <= 1'b1;
    cyc(10);
    chk("safe", 8'h03, {clk_sel_safe, irq_css});
    rd_csr(sim_pkg::ADDR_CSR, 8'h02, 8'h02);
    @(posedge clk);
    main_clk_lost <= 1'b0;
    cyc(10);
    chk("main", 8'h00, 8'(clk_sel_safe));
    rd_csr(sim_pkg::ADDR_CSR, 8'h02, 8'h02);
    rd_csr(sim_pkg::ADDR_CSR, 8'h02, 8'h00);
    cyc(3);
    $display("test clock guard done");
    complete_run();
  end
endmodule // tb_sim_top
`default_nettype wire
